/* File: shared/scsl_defs.vh */
// constants for the safety connection status logic
// assumes: included by the core files by bare name; definitions only
`ifndef SCSL_DEFS_VH
`define SCSL_DEFS_VH

// register byte offsets on the wishbone slave (one 32-bit word each)
`define SCSL_ADR_CTRL     8'h00
`define SCSL_ADR_STATUS   8'h04
`define SCSL_ADR_INT_STAT 8'h08
`define SCSL_ADR_INT_MASK 8'h0c
`define SCSL_ADR_POINT    8'h10
`define SCSL_ADR_W        8

// field positions inside the control register
`define SCSL_CTRL_INHIBIT_LSB 0
`define SCSL_CTRL_IOTYPE_LSB  8
`define SCSL_CTRL_RELAY_REQ   16

// field positions inside the status and interrupt registers
`define SCSL_ST_FAULT_LSB 0
`define SCSL_ST_RUN_LSB   8

// field positions inside the point summary register
`define SCSL_PT_ALLIN_LSB  0
`define SCSL_PT_ALLOUT_LSB 8
`define SCSL_PT_DCS_BIT    16
`define SCSL_PT_RLY1_BIT   17
`define SCSL_PT_RLY2_BIT   18

// reset values
`define SCSL_CTRL_RST 32'h0000_000f
`define SCSL_MASK_RST 32'h0000_0000

// which connection and points feed the safety functions
`define SCSL_DCS_CONN    0
`define SCSL_DCS_PT_A    0
`define SCSL_DCS_PT_B    1
`define SCSL_RLY_CONN    1
`define SCSL_RLY_PT_FB1  0
`define SCSL_RLY_PT_FB2  1
`define SCSL_RLY_PT_OUT1 2
`define SCSL_RLY_PT_OUT2 3

`endif

/* File: core/scsl_dual_monitor.v */
// dual-channel input safety function with built-in status monitoring
// assumes: channel values and their status bits are registered values from the top, same clock
`timescale 1ns/1ps
`default_nettype none

module scsl_dual_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire chan_a_i,      // channel a safety value
    input wire chan_b_i,      // channel b safety value
    input wire chan_a_ok_i,   // channel a point status
    input wire chan_b_ok_i,   // channel b point status
    output reg first_energize_out_o
);

    // energize only when both channels demand it and both statuses are healthy
    always @(posedge clk_i) begin
        if (rst_i) begin
            first_energize_out_o <= 1'b0;
        end else begin
            first_energize_out_o <= chan_a_i & chan_b_i & chan_a_ok_i & chan_b_ok_i;
        end
    end

endmodule // scsl_dual_monitor

`default_nettype wire

/* File: core/scsl_relay_out.v */
// relay-output safety function driving two outputs with feedback monitoring
// assumes: request and all status bits come from registered logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module scsl_relay_out (
    input wire clk_i,
    input wire rst_i,
    input wire request_i,      // energize request from upstream logic
    input wire fb1_ok_i,       // status of feedback 1
    input wire fb2_ok_i,       // status of feedback 2
    input wire out1_ok_i,      // status of the channel driven by output 1
    input wire out2_ok_i,      // status of the channel driven by output 2
    output reg first_energize_out_o,
    output reg second_energize_out_o
);

    // all four status bits gate both outputs; one bad bit drops both
    wire all_ok = fb1_ok_i & fb2_ok_i & out1_ok_i & out2_ok_i;

    // both outputs registered together so they never disagree
    always @(posedge clk_i) begin
        if (rst_i) begin
            first_energize_out_o <= 1'b0;
            second_energize_out_o <= 1'b0;
        end else begin
            first_energize_out_o <= request_i & all_ok;
            second_energize_out_o <= request_i & all_ok;
        end
    end

endmodule // scsl_relay_out

`default_nettype wire

/* File: core/scsl_top.v */
// safety connection status logic: per-connection status, data gating, point status,
// combined status and the two dual-channel safety functions, with a wishbone slave
// assumes: all non-bus inputs come from network logic on clk_i; scan_tick_i marks one
// evaluation pass and is a one-cycle pulse
//
// Overview of operation
// - fault flag per connection, 1 means faulted
// - fault clears safety data, forces run idle
// - run flag 1 while running producer refreshes
// - closed, task fault or program forces idle
// - io module run flag is inverse fault
// - valid and running data follows producer
// - inhibited device shows faulted, idle, zero data
// - faulted io module reads all items low
// - point bit needs channel good, link healthy
// - combined bits need all channels, healthy link
// - dual-channel function takes status a, b
// - relay function takes feedback, output statuses
// - energize only when every status is 1
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "scsl_defs.vh"

module scsl_top #(
    parameter N_CONN = 4,  // number of connections, at most 8
    parameter N_PT = 8     // points (and safety data bits) per connection
) (
    input wire clk_i,
    input wire rst_i,
    // classic wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`SCSL_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire irq_o,
    // evaluation pass and controller state
    input wire scan_tick_i,
    input wire task_fault_i,
    // per-connection transport status and data
    input wire [N_CONN-1:0] link_ok_i,
    input wire [N_CONN-1:0] conn_open_i,
    input wire [N_CONN-1:0] prod_run_i,
    input wire [N_CONN*N_PT-1:0] prod_data_i,
    input wire [N_CONN*N_PT-1:0] chan_in_ok_i,
    input wire [N_CONN*N_PT-1:0] chan_out_ok_i,
    // evaluated status and gated data
    output wire [N_CONN*N_PT-1:0] safe_data_o,
    output wire [N_CONN-1:0] conn_fault_flag_o,
    output wire [N_CONN-1:0] producer_run_flag_o,
    output wire [N_CONN*N_PT-1:0] point_in_ok_o,
    output wire [N_CONN*N_PT-1:0] point_out_ok_o,
    output wire [N_CONN-1:0] all_in_ok_o,
    output wire [N_CONN-1:0] all_out_ok_o,
    // safety function outputs
    output wire dual_channel_monitor_o,
    output wire relay_first_energize_out_o,
    output wire relay_second_energize_out_o
);

    // software-written control
    reg [N_CONN-1:0] inhibit_ff;    // per-connection inhibit
    reg [N_CONN-1:0] io_type_ff;    // 1 = safety io module, 0 = consumed connection
    reg relay_req_ff;               // software request for the relay function
    reg [31:0] int_mask_ff;         // interrupt mask, same layout as int_stat

    // evaluated state, refreshed once per pass
    reg [N_CONN-1:0] conn_fault_flag_ff;
    reg [N_CONN-1:0] producer_run_flag_ff;
    reg [N_CONN*N_PT-1:0] safe_data_ff;
    reg [N_CONN*N_PT-1:0] point_in_ok_ff;
    reg [N_CONN*N_PT-1:0] point_out_ok_ff;
    reg [N_CONN-1:0] all_in_ok_ff;
    reg [N_CONN-1:0] all_out_ok_ff;

    // sticky interrupt status
    reg [31:0] int_stat_ff;

    // next values for the evaluated state
    wire [N_CONN-1:0] nxt_fault;
    wire [N_CONN-1:0] nxt_run;
    wire [N_CONN*N_PT-1:0] nxt_data;
    wire [N_CONN*N_PT-1:0] nxt_pt_in;
    wire [N_CONN*N_PT-1:0] nxt_pt_out;
    wire [N_CONN-1:0] nxt_all_in;
    wire [N_CONN-1:0] nxt_all_out;

    // per-connection evaluation
    genvar c;
    generate
        for (c = 0; c < N_CONN; c = c + 1) begin : g_conn
            wire faulted;
            wire running;
            wire healthy_io;
            // an inhibited device or a broken link is a faulted connection
            assign faulted = inhibit_ff[c] | ~link_ok_i[c];
            // io modules carry no independent run information
            assign running = ~faulted & (io_type_ff[c] | (conn_open_i[c] & prod_run_i[c] & ~task_fault_i));
            assign nxt_fault[c] = faulted;
            assign nxt_run[c] = running;
            // data only passes while valid and running; otherwise it reads zero
            assign nxt_data[c*N_PT +: N_PT] = running ? prod_data_i[c*N_PT +: N_PT] : {N_PT{1'b0}};
            // point and combined bits exist only for healthy io module links
            assign healthy_io = io_type_ff[c] & ~faulted;
            assign nxt_pt_in[c*N_PT +: N_PT] = healthy_io ? chan_in_ok_i[c*N_PT +: N_PT] : {N_PT{1'b0}};
            assign nxt_pt_out[c*N_PT +: N_PT] = healthy_io ? chan_out_ok_i[c*N_PT +: N_PT] : {N_PT{1'b0}};
            assign nxt_all_in[c] = healthy_io & (&chan_in_ok_i[c*N_PT +: N_PT]);
            assign nxt_all_out[c] = healthy_io & (&chan_out_ok_i[c*N_PT +: N_PT]);
        end
    endgenerate

    // status refresh once per evaluation pass; functions read the result a cycle later
    always @(posedge clk_i) begin
        if (rst_i) begin
            // reset looks like a faulted, idle link: everything low but the fault flag
            conn_fault_flag_ff <= {N_CONN{1'b1}};
            producer_run_flag_ff <= {N_CONN{1'b0}};
            safe_data_ff <= {N_CONN*N_PT{1'b0}};
            point_in_ok_ff <= {N_CONN*N_PT{1'b0}};
            point_out_ok_ff <= {N_CONN*N_PT{1'b0}};
            all_in_ok_ff <= {N_CONN{1'b0}};
            all_out_ok_ff <= {N_CONN{1'b0}};
        end else if (scan_tick_i) begin
            conn_fault_flag_ff <= nxt_fault;
            producer_run_flag_ff <= nxt_run;
            safe_data_ff <= nxt_data;
            point_in_ok_ff <= nxt_pt_in;
            point_out_ok_ff <= nxt_pt_out;
            all_in_ok_ff <= nxt_all_in;
            all_out_ok_ff <= nxt_all_out;
        end
    end

    assign conn_fault_flag_o = conn_fault_flag_ff;
    assign producer_run_flag_o = producer_run_flag_ff;
    assign safe_data_o = safe_data_ff;
    assign point_in_ok_o = point_in_ok_ff;
    assign point_out_ok_o = point_out_ok_ff;
    assign all_in_ok_o = all_in_ok_ff;
    assign all_out_ok_o = all_out_ok_ff;

    // dual-channel input function on two points of its connection
    // the status it reads was latched at the pass edge, so it is always up to date first
    wire dcs_energize;
    scsl_dual_monitor u_dcs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .chan_a_i(safe_data_ff[`SCSL_DCS_CONN*N_PT + `SCSL_DCS_PT_A]),
        .chan_b_i(safe_data_ff[`SCSL_DCS_CONN*N_PT + `SCSL_DCS_PT_B]),
        .chan_a_ok_i(point_in_ok_ff[`SCSL_DCS_CONN*N_PT + `SCSL_DCS_PT_A]),
        .chan_b_ok_i(point_in_ok_ff[`SCSL_DCS_CONN*N_PT + `SCSL_DCS_PT_B]),
        .first_energize_out_o(dcs_energize)
    );
    assign dual_channel_monitor_o = dcs_energize;

    // relay function: request chained behind the input function, as a typical safety loop
    wire rly_first;
    wire rly_second;
    scsl_relay_out u_rly (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .request_i(relay_req_ff & dcs_energize),
        .fb1_ok_i(point_in_ok_ff[`SCSL_RLY_CONN*N_PT + `SCSL_RLY_PT_FB1]),
        .fb2_ok_i(point_in_ok_ff[`SCSL_RLY_CONN*N_PT + `SCSL_RLY_PT_FB2]),
        .out1_ok_i(point_out_ok_ff[`SCSL_RLY_CONN*N_PT + `SCSL_RLY_PT_OUT1]),
        .out2_ok_i(point_out_ok_ff[`SCSL_RLY_CONN*N_PT + `SCSL_RLY_PT_OUT2]),
        .first_energize_out_o(rly_first),
        .second_energize_out_o(rly_second)
    );
    assign relay_first_energize_out_o = rly_first;
    assign relay_second_energize_out_o = rly_second;

    // bus decode: a request is taken on the edge where ack is still low
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire bus_rd = bus_req & ~wb_we_i;

    // byte-lane write merge for a full register word
    function [31:0] merge_lanes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer b;
        begin
            merge_lanes = old_val;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge_lanes[b*8 +: 8] = new_val[b*8 +: 8];
                end
            end
        end
    endfunction

    // packed views of the readable registers
    reg [31:0] ctrl_word;
    reg [31:0] status_word;
    reg [31:0] point_word;
    always @* begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`SCSL_CTRL_INHIBIT_LSB +: N_CONN] = inhibit_ff;
        ctrl_word[`SCSL_CTRL_IOTYPE_LSB +: N_CONN] = io_type_ff;
        ctrl_word[`SCSL_CTRL_RELAY_REQ] = relay_req_ff;
        status_word = 32'h0000_0000;
        status_word[`SCSL_ST_FAULT_LSB +: N_CONN] = conn_fault_flag_ff;
        status_word[`SCSL_ST_RUN_LSB +: N_CONN] = producer_run_flag_ff;
        point_word = 32'h0000_0000;
        point_word[`SCSL_PT_ALLIN_LSB +: N_CONN] = all_in_ok_ff;
        point_word[`SCSL_PT_ALLOUT_LSB +: N_CONN] = all_out_ok_ff;
        point_word[`SCSL_PT_DCS_BIT] = dcs_energize;
        point_word[`SCSL_PT_RLY1_BIT] = rly_first;
        point_word[`SCSL_PT_RLY2_BIT] = rly_second;
    end

    // merged control write, used only when the control word is addressed
    wire [31:0] ctrl_wr = merge_lanes(ctrl_word, wb_dat_i, wb_sel_i);

    // control and mask registers; ack follows one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            inhibit_ff <= {N_CONN{1'b1}};  // start inhibited until software releases
            io_type_ff <= {N_CONN{1'b0}};
            relay_req_ff <= 1'b0;
            int_mask_ff <= `SCSL_MASK_RST;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_wr && wb_adr_i == `SCSL_ADR_CTRL) begin
                inhibit_ff <= ctrl_wr[`SCSL_CTRL_INHIBIT_LSB +: N_CONN];
                io_type_ff <= ctrl_wr[`SCSL_CTRL_IOTYPE_LSB +: N_CONN];
                relay_req_ff <= ctrl_wr[`SCSL_CTRL_RELAY_REQ];
            end
            if (bus_wr && wb_adr_i == `SCSL_ADR_INT_MASK) begin
                int_mask_ff <= merge_lanes(int_mask_ff, wb_dat_i, wb_sel_i);
            end
        end
    end

    // read data registered together with ack; unmapped addresses read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (wb_adr_i)
                `SCSL_ADR_CTRL: begin
                    wb_dat_o <= ctrl_word;
                end
                `SCSL_ADR_STATUS: begin
                    wb_dat_o <= status_word;
                end
                `SCSL_ADR_INT_STAT: begin
                    wb_dat_o <= int_stat_ff;
                end
                `SCSL_ADR_INT_MASK: begin
                    wb_dat_o <= int_mask_ff;
                end
                `SCSL_ADR_POINT: begin
                    wb_dat_o <= point_word;
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // events: connection became faulted, producer left run mode
    reg [31:0] evt;
    always @* begin
        evt = 32'h0000_0000;
        if (scan_tick_i) begin
            evt[`SCSL_ST_FAULT_LSB +: N_CONN] = nxt_fault & ~conn_fault_flag_ff;
            evt[`SCSL_ST_RUN_LSB +: N_CONN] = ~nxt_run & producer_run_flag_ff;
        end
    end

    // sticky status, cleared by a read; a new event in the read cycle survives
    wire stat_rd = bus_rd & (wb_adr_i == `SCSL_ADR_INT_STAT);
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_stat_ff <= 32'h0000_0000;
        end else if (stat_rd) begin
            int_stat_ff <= evt;
        end else begin
            int_stat_ff <= int_stat_ff | evt;
        end
    end

    // level interrupt while any unmasked status bit is set
    assign irq_o = |(int_stat_ff & int_mask_ff);

endmodule // scsl_top

`default_nettype wire

/* File: bench/scsl_producer_model.sv */
// remote safety producer: link state, open state, run mode, data and channel health
// assumes: bench changes the request inputs just after a clock edge; same clock as the core
`timescale 1ns/1ps
`default_nettype none

module scsl_producer_model #(
    parameter N_CONN = 4,
    parameter N_PT = 8
) (
    input wire logic clk_i,
    input wire logic [N_CONN-1:0] link_req_i, // transport link held up
    input wire logic [N_CONN-1:0] open_req_i, // connection opened
    input wire logic [N_CONN-1:0] run_req_i, // producer in run mode
    input wire logic [N_CONN*N_PT-1:0] data_req_i, // data sent while running
    input wire logic [N_CONN*N_PT-1:0] in_req_i, // input channel health
    input wire logic [N_CONN*N_PT-1:0] out_req_i, // output channel health
    output logic [N_CONN-1:0] link_ok_o,
    output logic [N_CONN-1:0] conn_open_o,
    output logic [N_CONN-1:0] prod_run_o,
    output logic [N_CONN*N_PT-1:0] prod_data_o,
    output logic [N_CONN*N_PT-1:0] chan_in_ok_o,
    output logic [N_CONN*N_PT-1:0] chan_out_ok_o
);
    // health settles a cycle ahead of any evaluation pass the bench starts
    always @(posedge clk_i) begin
        link_ok_o <= link_req_i;
        conn_open_o <= open_req_i;
        prod_run_o <= run_req_i;
        chan_in_ok_o <= in_req_i;
        chan_out_ok_o <= out_req_i;
        for (int c = 0; c < N_CONN; c++) begin
            // an idle producer still sends stale data, flipping, so gating is really tested
            if (run_req_i[c]) begin
                prod_data_o[c*N_PT +: N_PT] <= data_req_i[c*N_PT +: N_PT];
            end else begin
                prod_data_o[c*N_PT +: N_PT] <= ~prod_data_o[c*N_PT +: N_PT];
            end
        end
    end
endmodule // scsl_producer_model

`default_nettype wire

/* File: bench/scsl_top_props.sv */
// checker for the status logic, bound to the top module's ports
// assumes: one clock, synchronous active-high reset, status latched on scan_tick_i
`timescale 1ns/1ps
`default_nettype none

module scsl_top_props #(
    parameter N_CONN = 4,
    parameter N_PT = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire irq_o,
    input wire scan_tick_i,
    input wire [N_CONN-1:0] link_ok_i,
    input wire [N_CONN*N_PT-1:0] prod_data_i,
    input wire [N_CONN*N_PT-1:0] chan_in_ok_i,
    input wire [N_CONN*N_PT-1:0] safe_data_o,
    input wire [N_CONN-1:0] conn_fault_flag_o,
    input wire [N_CONN-1:0] producer_run_flag_o,
    input wire [N_CONN*N_PT-1:0] point_in_ok_o,
    input wire [N_CONN*N_PT-1:0] point_out_ok_o,
    input wire [N_CONN-1:0] all_in_ok_o,
    input wire [N_CONN-1:0] all_out_ok_o,
    input wire dual_channel_monitor_o,
    input wire relay_first_energize_out_o,
    input wire relay_second_energize_out_o
);
    wire [N_CONN*N_PT-1:0] flt_mask; // fault flag spread over each connection's points
    wire [N_CONN*N_PT-1:0] run_mask; // run flag spread the same way
    genvar c;
    generate
        for (c = 0; c < N_CONN; c = c + 1) begin : g_mask
            assign flt_mask[c*N_PT +: N_PT] = {N_PT{conn_fault_flag_o[c]}};
            assign run_mask[c*N_PT +: N_PT] = {N_PT{producer_run_flag_o[c]}};
        end
    endgenerate

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_NO_FAULT_RUN: assert property (!(|(conn_fault_flag_o & producer_run_flag_o)))
        else $error("fault and run flags both set");
    AST_IDLE_ZERO: assert property ((safe_data_o & ~run_mask) == '0)
        else $error("data nonzero on idle connection");
    AST_FAULT_POINTS: assert property (((point_in_ok_o | point_out_ok_o) & flt_mask) == '0)
        else $error("point status high on faulted connection");
    AST_FAULT_ALL: assert property (((all_in_ok_o | all_out_ok_o) & conn_fault_flag_o) == '0)
        else $error("combined status high on faulted connection");
    AST_LINK_FAULT: assert property (scan_tick_i |=> (~$past(link_ok_i) & ~conn_fault_flag_o) == '0)
        else $error("lost link not flagged as fault");
    AST_CHAN_POINT: assert property (scan_tick_i |=> (point_in_ok_o & ~$past(chan_in_ok_i)) == '0)
        else $error("point status high on bad channel");
    AST_DATA_SOURCE: assert property (scan_tick_i |=> (safe_data_o & ~$past(prod_data_i)) == '0)
        else $error("data bit not supplied by producer");
    AST_HOLD_PASS: assert property (!scan_tick_i |=> $stable(conn_fault_flag_o) && $stable(safe_data_o))
        else $error("status changed without a pass");
    AST_DCS_GATE: assert property (dual_channel_monitor_o |-> $past(point_in_ok_o[0]) && $past(point_in_ok_o[1]))
        else $error("dual-channel output on bad status");
    AST_RELAY_GATE: assert property ((relay_first_energize_out_o || relay_second_energize_out_o) |->
        $past(dual_channel_monitor_o) && $past(point_in_ok_o[N_PT]) && $past(point_in_ok_o[N_PT+1])
        && $past(point_out_ok_o[N_PT+2]) && $past(point_out_ok_o[N_PT+3]))
        else $error("relay output on bad status");

    // main scenarios
    cover property (scan_tick_i ##3 relay_first_energize_out_o);
    cover property ($rose(irq_o));
    cover property (dual_channel_monitor_o ##1 !dual_channel_monitor_o);
endmodule // scsl_top_props

bind scsl_top scsl_top_props #(.N_CONN(N_CONN), .N_PT(N_PT)) u_props (.*);

`default_nettype wire

/* File: bench/scsl_top_test.sv */
// self-checking bench for the safety connection status logic, default sizes
// assumes: core, defs header, producer model and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "scsl_defs.vh"

module scsl_top_test;
    localparam logic [31:0] DATA = 32'h5aa5_3c03; // conn 0 holds both dual-channel bits high
    logic clk_i;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, irq_o, scan_tick_i = 1'b0, task_fault_i = 1'b0;
    logic [3:0] link_ok_i, conn_open_i, prod_run_i, conn_fault_flag_o, producer_run_flag_o, all_in_ok_o, all_out_ok_o;
    logic [3:0] link_r = 4'hf, open_r = 4'hf, run_r = 4'hf; // producer requests
    logic [31:0] prod_data_i, chan_in_ok_i, chan_out_ok_i, safe_data_o, point_in_ok_o, point_out_ok_o;
    logic [31:0] in_r = 32'hffff_ffff, out_r = 32'hffff_ffff;
    logic dual_channel_monitor_o, relay_first_energize_out_o, relay_second_energize_out_o;
    int fail_count = 0, n_tests = 0;

    scsl_top dut (.*);
    scsl_producer_model prod (.clk_i(clk_i), .link_req_i(link_r), .open_req_i(open_r), .run_req_i(run_r),
        .data_req_i(DATA), .in_req_i(in_r), .out_req_i(out_r), .link_ok_o(link_ok_i), .conn_open_o(conn_open_i),
        .prod_run_o(prod_run_i), .prod_data_o(prod_data_i), .chan_in_ok_o(chan_in_ok_i), .chan_out_ok_o(chan_out_ok_i));

    // one classic cycle; entered just after an edge, leaves one idle cycle behind
    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50) fail_count++;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbx(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // one pass: the model takes its requests, then a one-cycle tick, then the functions settle
    task automatic scan;
        @(posedge clk_i);
        scan_tick_i <= 1'b1;
        @(posedge clk_i);
        scan_tick_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // a full run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_sim;
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(conn_fault_flag_o, 4'hf);
        chk(safe_data_o, 32'h0);
        rd(`SCSL_ADR_CTRL, `SCSL_CTRL_RST);
        rd(`SCSL_ADR_STATUS, 32'h0000_000f);
        rd(`SCSL_ADR_INT_MASK, `SCSL_MASK_RST);
        rd(8'h20, 32'h0);
        $display("end of test 1: reset and unmapped read");
        wr(`SCSL_ADR_CTRL, 32'h0);
        scan;
        chk(conn_fault_flag_o, 4'h0);
        chk(safe_data_o, DATA);
        chk(point_in_ok_o, 32'h0);
        rd(`SCSL_ADR_STATUS, 32'h0000_0f00);
        $display("end of test 2: consumed connections running");
        run_r <= 4'b1110;
        open_r <= 4'b1101;
        scan;
        chk(conn_fault_flag_o, 4'h0);
        chk(producer_run_flag_o, 4'b1100);
        chk(safe_data_o, DATA & 32'hffff_0000);
        task_fault_i <= 1'b1;
        scan;
        chk(producer_run_flag_o, 4'h0);
        chk(safe_data_o, 32'h0);
        task_fault_i <= 1'b0;
        run_r <= 4'hf;
        open_r <= 4'hf;
        scan;
        $display("end of test 3: idle producers");
        wbx(1'b0, `SCSL_ADR_INT_STAT, 32'h0, q);
        wr(`SCSL_ADR_INT_MASK, 32'h0000_0004);
        chk(irq_o, 1'b0);
        link_r <= 4'b1011;
        scan;
        chk(irq_o, 1'b1);
        chk(conn_fault_flag_o, 4'b0100);
        chk(producer_run_flag_o, 4'b1011);
        chk(safe_data_o, DATA & 32'hff00_ffff);
        rd(`SCSL_ADR_INT_STAT, 32'h0000_0404);
        chk(irq_o, 1'b0);
        link_r <= 4'hf;
        $display("end of test 4: link loss and interrupt");
        wr(`SCSL_ADR_CTRL, 32'h0000_0008);
        scan;
        chk(conn_fault_flag_o, 4'b1000);
        chk(producer_run_flag_o, 4'b0111);
        chk(safe_data_o, DATA & 32'h00ff_ffff);
        $display("end of test 5: inhibited device");
        wr(`SCSL_ADR_CTRL, 32'h0001_0f00);
        run_r <= 4'b0111;
        scan;
        chk(producer_run_flag_o, 4'hf);
        run_r <= 4'hf; // io conn data passes regardless of run, so stop the stale toggling
        chk(point_in_ok_o, 32'hffff_ffff);
        chk(all_out_ok_o, 4'hf);
        chk(dual_channel_monitor_o, 1'b1);
        chk({relay_first_energize_out_o, relay_second_energize_out_o}, 2'b11);
        rd(`SCSL_ADR_POINT, 32'h0007_0f0f);
        in_r <= 32'hffff_ffdf;
        scan;
        chk(point_in_ok_o, 32'hffff_ffdf);
        chk(all_in_ok_o, 4'b1110);
        out_r <= 32'hffff_f7ff;
        scan;
        chk(all_out_ok_o, 4'b1101);
        chk(point_out_ok_o, 32'hffff_f7ff);
        chk({relay_first_energize_out_o, relay_second_energize_out_o}, 2'b00);
        in_r <= 32'hffff_ffdd;
        scan;
        chk(dual_channel_monitor_o, 1'b0);
        link_r <= 4'b1101;
        scan;
        chk(point_in_ok_o, 32'hffff_00dd);
        chk(all_in_ok_o, 4'b1100);
        chk(producer_run_flag_o, 4'b1101);
        chk(safe_data_o, DATA & 32'hffff_00ff);
        $display("end of test 6: safety module status and functions");
        end_sim;
    end
endmodule // scsl_top_test

`default_nettype wire
